// ==== hw/pfm_pkg.sv ====
package pfm_pkg;

    // ------------------------------------------------------------
    // pin numbering: port a 0..5, port b 6..13, port c 14..17
    // ------------------------------------------------------------
    localparam int PFM_NPINS = 18;
    localparam int PFM_AW    = 8;
    localparam int PFM_DW    = 32;

    localparam int PFM_PIN_A0 = 0;
    localparam int PFM_PIN_A2 = 2;
    localparam int PFM_PIN_A3 = 3;
    localparam int PFM_PIN_A4 = 4;
    localparam int PFM_PIN_A5 = 5;
    localparam int PFM_PIN_B5 = 11;
    localparam int PFM_PIN_B6 = 12;
    localparam int PFM_PIN_B7 = 13;
    localparam int PFM_PIN_C0 = 14;
    localparam int PFM_PIN_C1 = 15;

    typedef logic [PFM_NPINS-1:0] pfm_pins_t;

    // pins b2..b5 and c0..c3 may join the ganged output
    localparam pfm_pins_t PFM_GANG_MASK = 18'h3cf00;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [PFM_AW-1:0] PFM_OFS_DATA   = 8'h00;
    localparam logic [PFM_AW-1:0] PFM_OFS_DIR    = 8'h04;
    localparam logic [PFM_AW-1:0] PFM_OFS_PULL   = 8'h08;
    localparam logic [PFM_AW-1:0] PFM_OFS_DRIVE  = 8'h0c;
    localparam logic [PFM_AW-1:0] PFM_OFS_SLEW   = 8'h10;
    localparam logic [PFM_AW-1:0] PFM_OFS_GANG   = 8'h14;
    localparam logic [PFM_AW-1:0] PFM_OFS_OPTS1  = 8'h18;
    localparam logic [PFM_AW-1:0] PFM_OFS_OPTS2  = 8'h1c;
    localparam logic [PFM_AW-1:0] PFM_OFS_STATUS = 8'h20;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int PFM_O1_DBG_EN = 0;
    localparam int PFM_O1_RST_EN = 1;
    localparam int PFM_O2_I2C_PS = 0;
    localparam int PFM_O2_TMR_PS = 1;
    localparam int PFM_ST_MODE   = 0;
    localparam int PFM_ST_DBG_EN = 1;
    localparam int PFM_ST_RST_EN = 2;

    localparam pfm_pins_t PFM_RST_PINS = 18'h00000;
    localparam pfm_pins_t PFM_RST_PULL = 18'h00010;
    localparam logic      PFM_RST_DBG  = 1'b1;
    localparam logic      PFM_RST_RPE  = 1'b0;
    localparam logic      PFM_RST_SEL  = 1'b0;

    // debug link bit time in debug clock cycles
    localparam int PFM_DBG_BIT_CYCLES = 16;

    typedef enum logic [0:0] {
        PFM_MODE_RUN = 1'b0,
        PFM_MODE_BDM = 1'b1
    } pfm_mode_t;

    // one peripheral function offered to a pin
    typedef struct packed {
        logic en;
        logic o;
        logic oe;
    } pfm_fn_t;

    typedef struct packed {
        pfm_pins_t en;
        pfm_pins_t o;
        pfm_pins_t oe;
    } pfm_vec_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [PFM_AW-1:0] paddr;
        logic [PFM_DW-1:0] pwdata;
    } pfm_apb_req_t;

endpackage

// ==== hw/pfm_pin_mux.sv ====
// Overview of operation
// R1 - sample debug pin as mode during reset; the code samples it only on power-on or forced reset
// R2 - debug pin serves debug link after reset
// R3 - debug enable turns on pin pull-up
// R4 - every reset sets debug pin enable
// R5 - high mode pin gives run mode
// R6 - low mode pin gives background mode
// R7 - debug bit time is sixteen cycles
// R8 - debug controller speed-up pulses drive high
// R9 - outputs get drive strength and slew
// R10 - inputs may enable pull-up
// R11 - reset leaves pins input, pull-up off; the code resets pin a4 with its pull-up on
// R12 - direction bit selects port read source
// R13 - peripheral drives output buffer enable
// R14 - i2c pins movable, default a2/a3
// R15 - timer pins movable, default a0/b5
// R16 - ganged output beats digital peripherals
// R17 - gang pins copy port c bit zero
// R18 - comparator and converter share pin
// R19 - reset pin never drives high
// R20 - higher alternate function wins the pin
// R21 - reset pin enable holds until power-on
//
// Added by the designer: register access over APB and the placing of the registers.
module pfm_pin_mux #(
    parameter int DBG_BIT_CYCLES = pfm_pkg::PFM_DBG_BIT_CYCLES
) (
    // clock, reset, enable
    input  wire logic                      clk,
    input  wire logic                      rst,
    input  wire logic                      ce,
    // apb slave
    input  wire pfm_pkg::pfm_apb_req_t     apb_req,
    output logic [pfm_pkg::PFM_DW-1:0]     prdata,
    output logic                           pready,
    output logic                           pslverr,
    // reset causes and reset pin
    input  wire logic                      por_reset,
    input  wire logic                      force_reset,
    input  wire logic                      reset_drive_low,
    output logic                           ext_reset_req,
    output logic                           active_background,
    // background debug controller
    input  wire pfm_pkg::pfm_fn_t          dbg_drive,
    output logic                           dbg_in,
    output logic                           debug_bit_tick,
    // relocatable peripherals
    input  wire pfm_pkg::pfm_fn_t          i2c_scl,
    input  wire pfm_pkg::pfm_fn_t          i2c_sda,
    input  wire pfm_pkg::pfm_fn_t          tmr1_ch0,
    input  wire pfm_pkg::pfm_fn_t          tmr1_ch1,
    output logic                           i2c_scl_in,
    output logic                           i2c_sda_in,
    output logic                           tmr1_ch0_in,
    output logic                           tmr1_ch1_in,
    // fixed alternate functions, already ranked per pin
    input  wire pfm_pkg::pfm_vec_t         alt_fn,
    // analog claims
    input  wire pfm_pkg::pfm_pins_t        adc_en,
    input  wire pfm_pkg::pfm_pins_t        acmp_en,
    output pfm_pkg::pfm_pins_t             analog_connect,
    // pads
    input  wire pfm_pkg::pfm_pins_t        pad_in,
    output pfm_pkg::pfm_pins_t             pad_out,
    output pfm_pkg::pfm_pins_t             pad_oe,
    output pfm_pkg::pfm_pins_t             pad_pullup,
    output pfm_pkg::pfm_pins_t             pad_drive_high,
    output pfm_pkg::pfm_pins_t             pad_slew
);
    import pfm_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic pfm_vec_t place(input pfm_fn_t f, input int idx);
        pfm_vec_t v;
        v = '0;
        v.en[idx] = f.en;
        v.o[idx]  = f.o;
        v.oe[idx] = f.oe;
        return v;
    endfunction

    function automatic int pick(input logic sel, input int a, input int b);
        return sel ? b : a;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    pfm_pins_t data_reg;
    pfm_pins_t dir_reg;
    pfm_pins_t pull_reg;
    pfm_pins_t drive_reg;
    pfm_pins_t slew_reg;
    pfm_pins_t gang_reg;
    logic      dbg_en_reg;
    logic      rst_en_reg;
    logic      i2c_ps_reg;
    logic      tmr_ps_reg;
    pfm_mode_t mode_reg;
    logic [3:0] bit_cnt_reg;
    logic      tick_reg;
    logic [PFM_DW-1:0] prdata_reg;
    logic      err_reg;
    pfm_pins_t out_reg;
    pfm_pins_t oe_reg;
    pfm_pins_t pu_reg;
    pfm_pins_t dh_reg;
    pfm_pins_t sl_reg;
    pfm_pins_t ana_reg;
    logic      ext_rst_reg;
    logic      dbg_in_reg;
    logic [3:0] pin_in_reg;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic setup_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    wire logic setup    = apb_req.psel & ~apb_req.penable;
    wire logic wr       = apb_req.psel & apb_req.penable & apb_req.pwrite;
    wire logic [PFM_AW-1:0] adr = apb_req.paddr;
    wire pfm_pins_t wd  = apb_req.pwdata[PFM_NPINS-1:0];

    wire logic hit_data  = adr == PFM_OFS_DATA;
    wire logic hit_dir   = adr == PFM_OFS_DIR;
    wire logic hit_pull  = adr == PFM_OFS_PULL;
    wire logic hit_drive = adr == PFM_OFS_DRIVE;
    wire logic hit_slew  = adr == PFM_OFS_SLEW;
    wire logic hit_gang  = adr == PFM_OFS_GANG;
    wire logic hit_o1    = adr == PFM_OFS_OPTS1;
    wire logic hit_o2    = adr == PFM_OFS_OPTS2;
    wire logic hit_st    = adr == PFM_OFS_STATUS;
    wire logic mapped    = hit_data | hit_dir | hit_pull | hit_drive | hit_slew
                         | hit_gang | hit_o1 | hit_o2 | hit_st;

    // reading the data register follows the direction bit per pin
    wire pfm_pins_t port_rd = (dir_reg & data_reg) | (~dir_reg & pad_in); // R12

    wire logic [PFM_DW-1:0] opts1_rd = PFM_DW'({rst_en_reg, dbg_en_reg});
    wire logic [PFM_DW-1:0] opts2_rd = PFM_DW'({tmr_ps_reg, i2c_ps_reg});
    wire logic [PFM_DW-1:0] stat_rd  = PFM_DW'({rst_en_reg, dbg_en_reg, mode_reg});

    wire logic [PFM_DW-1:0] rd_mux =
        hit_data  ? PFM_DW'(port_rd)   :
        hit_dir   ? PFM_DW'(dir_reg)   :
        hit_pull  ? PFM_DW'(pull_reg)  :
        hit_drive ? PFM_DW'(drive_reg) :
        hit_slew  ? PFM_DW'(slew_reg)  :
        hit_gang  ? PFM_DW'(gang_reg & PFM_GANG_MASK) :
        hit_o1    ? opts1_rd :
        hit_o2    ? opts2_rd :
        hit_st    ? stat_rd  : '0;

    // ------------------------------------------------------------
    // relocatable functions
    // ------------------------------------------------------------
    wire integer scl_pin = pick(i2c_ps_reg, PFM_PIN_A3, PFM_PIN_B7); // R14
    wire integer sda_pin = pick(i2c_ps_reg, PFM_PIN_A2, PFM_PIN_B6); // R14
    wire integer ch0_pin = pick(tmr_ps_reg, PFM_PIN_A0, PFM_PIN_C0); // R15
    wire integer ch1_pin = pick(tmr_ps_reg, PFM_PIN_B5, PFM_PIN_C1); // R15

    // the four relocatable functions never share a pin, so or-ing is safe
    wire pfm_vec_t v_scl = place(i2c_scl, scl_pin);
    wire pfm_vec_t v_sda = place(i2c_sda, sda_pin);
    wire pfm_vec_t v_ch0 = place(tmr1_ch0, ch0_pin);
    wire pfm_vec_t v_ch1 = place(tmr1_ch1, ch1_pin);
    wire pfm_vec_t reloc = v_scl | v_sda | v_ch0 | v_ch1;

    // ------------------------------------------------------------
    // per-pin ownership
    // ------------------------------------------------------------
    pfm_pins_t nx_o;
    pfm_pins_t nx_oe;
    pfm_pins_t nx_pu;
    pfm_pins_t nx_dh;
    pfm_pins_t nx_sl;
    pfm_pins_t nx_ana;

    wire pfm_pins_t gang_on = gang_reg & PFM_GANG_MASK;

    genvar i;
    generate
        for (i = 0; i < PFM_NPINS; i++) begin : g_pin
            wire logic ana  = adc_en[i] | acmp_en[i];               // R18
            // rank: gang, relocated peripheral, fixed alternate, port
            wire logic d_o  = gang_on[i]  ? data_reg[PFM_PIN_C0] :  // R16 R17
                              reloc.en[i] ? reloc.o[i] :            // R20
                              alt_fn.en[i] ? alt_fn.o[i] : data_reg[i];
            wire logic d_oe = gang_on[i]  ? 1'b1 :                  // R16
                              reloc.en[i] ? reloc.oe[i] :           // R13
                              alt_fn.en[i] ? alt_fn.oe[i] : dir_reg[i];
            wire logic g_oe = d_oe & ~ana;
            if (i == PFM_PIN_A4) begin : g_dbg
                // debug controller owns the buffer, incl. speed-up pulses
                assign nx_o[i]  = dbg_en_reg ? dbg_drive.o : d_o;   // R2 R8
                assign nx_oe[i] = dbg_en_reg ? dbg_drive.oe : g_oe; // R2 R8
                assign nx_pu[i] = dbg_en_reg | (pull_reg[i] & ~g_oe); // R3 R10
            end else if (i == PFM_PIN_A5) begin : g_rst
                // only ever pulls low: an active high could fight the line
                assign nx_o[i]  = rst_en_reg ? 1'b0 : d_o;
                assign nx_oe[i] = rst_en_reg ? reset_drive_low
                                             : (g_oe & ~d_o);       // R19
                assign nx_pu[i] = rst_en_reg | (pull_reg[i] & ~g_oe);
            end else begin : g_io
                assign nx_o[i]  = d_o;
                assign nx_oe[i] = g_oe;
                assign nx_pu[i] = pull_reg[i] & ~g_oe;              // R10
            end
            assign nx_dh[i]  = gang_on[i] ? drive_reg[PFM_PIN_C0] : drive_reg[i]; // R9 R17
            assign nx_sl[i]  = gang_on[i] ? slew_reg[PFM_PIN_C0] : slew_reg[i];   // R9 R17
            assign nx_ana[i] = ana;                                 // R18
        end
    endgenerate

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            data_reg  <= PFM_RST_PINS;
            dir_reg   <= PFM_RST_PINS;                              // R11
            pull_reg  <= PFM_RST_PINS;                              // R11
            drive_reg <= PFM_RST_PINS;
            slew_reg  <= PFM_RST_PINS;
            gang_reg  <= PFM_RST_PINS;
            i2c_ps_reg <= PFM_RST_SEL;                              // R14
            tmr_ps_reg <= PFM_RST_SEL;                              // R15
        end else if (ce && wr) begin
            if (hit_data) data_reg <= wd;
            if (hit_dir) dir_reg <= wd;
            if (hit_pull) pull_reg <= wd;                           // R10
            if (hit_drive) drive_reg <= wd;                         // R9
            if (hit_slew) slew_reg <= wd;                           // R9
            if (hit_gang) gang_reg <= wd & PFM_GANG_MASK;
            if (hit_o2) begin
                i2c_ps_reg <= apb_req.pwdata[PFM_O2_I2C_PS];
                tmr_ps_reg <= apb_req.pwdata[PFM_O2_TMR_PS];
            end
        end
    end

    // ------------------------------------------------------------
    // option bits and boot mode
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            dbg_en_reg <= PFM_RST_DBG;                              // R4
            if (por_reset) rst_en_reg <= PFM_RST_RPE;               // R21
            // the pin level held at release decides the mode
            if (por_reset || force_reset) begin
                mode_reg <= pad_in[PFM_PIN_A4] ? PFM_MODE_RUN       // R1 R5
                                               : PFM_MODE_BDM;      // R6
            end
        end else if (ce && wr && hit_o1) begin
            dbg_en_reg <= apb_req.pwdata[PFM_O1_DBG_EN];            // R4
            // once set it sticks; only power-on clears it
            rst_en_reg <= rst_en_reg | apb_req.pwdata[PFM_O1_RST_EN]; // R21
        end
    end

    // ------------------------------------------------------------
    // debug bit-time tick
    // ------------------------------------------------------------
    wire logic bit_last = bit_cnt_reg == 4'(DBG_BIT_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (rst || !dbg_en_reg) begin
            bit_cnt_reg <= '0;
            tick_reg    <= 1'b0;
        end else if (ce) begin
            bit_cnt_reg <= bit_last ? '0 : bit_cnt_reg + 4'h1;      // R7
            tick_reg    <= bit_last;                                // R7
        end
    end

    // ------------------------------------------------------------
    // apb answer
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_reg <= '0;
            err_reg    <= 1'b0;
        end else if (ce && setup) begin
            prdata_reg <= setup_rd && mapped ? rd_mux : '0;
            err_reg    <= ~mapped;
        end
    end

    // ------------------------------------------------------------
    // pad and peripheral output flops
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            out_reg <= PFM_RST_PINS;
            oe_reg  <= PFM_RST_PINS;                                // R11
            pu_reg  <= PFM_RST_PULL;                                // R3 R11
            dh_reg  <= PFM_RST_PINS;
            sl_reg  <= PFM_RST_PINS;
            ana_reg <= PFM_RST_PINS;
            ext_rst_reg <= 1'b0;
            dbg_in_reg  <= 1'b1;
            pin_in_reg  <= '0;
        end else if (ce) begin
            out_reg <= nx_o;
            oe_reg  <= nx_oe;
            pu_reg  <= nx_pu;
            dh_reg  <= nx_dh;
            sl_reg  <= nx_sl;
            ana_reg <= nx_ana;
            ext_rst_reg <= rst_en_reg & ~pad_in[PFM_PIN_A5];        // R21
            dbg_in_reg  <= pad_in[PFM_PIN_A4] | ~dbg_en_reg;        // R2
            pin_in_reg  <= {pad_in[ch1_pin], pad_in[ch0_pin],
                            pad_in[sda_pin], pad_in[scl_pin]};      // R14 R15
        end
    end

    assign prdata            = prdata_reg;
    assign pready            = ce;
    assign pslverr           = err_reg;
    assign ext_reset_req     = ext_rst_reg;
    assign active_background = mode_reg == PFM_MODE_BDM;            // R6
    assign dbg_in            = dbg_in_reg;
    assign debug_bit_tick    = tick_reg;
    assign i2c_scl_in        = pin_in_reg[0];
    assign i2c_sda_in        = pin_in_reg[1];
    assign tmr1_ch0_in       = pin_in_reg[2];
    assign tmr1_ch1_in       = pin_in_reg[3];
    assign analog_connect    = ana_reg;
    assign pad_out           = out_reg;
    assign pad_oe            = oe_reg;
    assign pad_pullup        = pu_reg;
    assign pad_drive_high    = dh_reg;
    assign pad_slew          = sl_reg;

endmodule

// ==== verif/pfm_pin_mux_checker.sv ====
module pfm_pin_mux_checker #(
    parameter int DBG_BIT_CYCLES = pfm_pkg::PFM_DBG_BIT_CYCLES
) (
    // clock and reset
    input wire logic                  clk,
    input wire logic                  rst,
    input wire logic                  ce,
    // bus, reset and debug
    input wire pfm_pkg::pfm_apb_req_t apb_req,
    input wire logic                  pslverr,
    input wire logic                  por_reset,
    input wire logic                  force_reset,
    input wire logic                  active_background,
    input wire logic                  dbg_in,
    input wire logic                  debug_bit_tick,
    // pins
    input wire pfm_pkg::pfm_pins_t    adc_en,
    input wire pfm_pkg::pfm_pins_t    acmp_en,
    input wire pfm_pkg::pfm_pins_t    analog_connect,
    input wire pfm_pkg::pfm_pins_t    pad_in,
    input wire pfm_pkg::pfm_pins_t    pad_out,
    input wire pfm_pkg::pfm_pins_t    pad_oe,
    input wire pfm_pkg::pfm_pins_t    pad_pullup,
    input wire pfm_pkg::pfm_pins_t    pad_drive_high,
    input wire pfm_pkg::pfm_pins_t    pad_slew
);
    timeunit 1ns;
    timeprecision 1ps;
    import pfm_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ----------------------------------------
    // tick spacing
    // ----------------------------------------
    // no reference before the first tick
    logic [7:0] gap_reg;
    logic       armed_reg;
    wire pfm_pins_t ana = adc_en | acmp_en;
    always_ff @(posedge clk) begin
        if (rst) begin
            gap_reg   <= 8'h00;
            armed_reg <= 1'b0;
        end else if (ce) begin
            gap_reg   <= debug_bit_tick ? 8'h01 : gap_reg + 8'h01;
            armed_reg <= armed_reg | debug_bit_tick;
        end
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_reset_pads;
        $fell(rst) |-> pad_oe == '0 && pad_pullup == 18'h00010 && pad_drive_high == '0
            && pad_slew == '0 && analog_connect == '0 && dbg_in && !debug_bit_tick;
    endproperty
    a_reset_pads: assert property (p_reset_pads) else $error("reset pads");
    property p_mode;
        $fell(rst) && $past(por_reset || force_reset)
            |-> active_background == !$past(pad_in[PFM_PIN_A4]);
    endproperty
    a_mode: assert property (p_mode) else $error("boot mode");
    property p_tick;
        debug_bit_tick && armed_reg |-> gap_reg == DBG_BIT_CYCLES;
    endproperty
    a_tick: assert property (p_tick) else $error("tick spacing");
    property p_slverr;
        apb_req.psel && !apb_req.penable && ce |=> pslverr == ($past(apb_req.paddr) > 8'h20);
    endproperty
    a_slverr: assert property (p_slverr) else $error("slave error");
    property p_analog_link;
        ce && ana == $past(ana) |=> analog_connect == $past(ana);
    endproperty
    a_analog_link: assert property (p_analog_link) else $error("analog link");
    property p_analog_oe;
        ce && $past(ce) && ana == $past(ana) |=> (pad_oe & $past(ana)) == '0;
    endproperty
    a_analog_oe: assert property (p_analog_oe) else $error("analog pin driven");
    property p_open_drain;
        pad_oe[PFM_PIN_A5] |-> !pad_out[PFM_PIN_A5];
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("reset pin high");
    property p_pull_oe;
        (pad_pullup & pad_oe & ~18'h00030) == '0;
    endproperty
    a_pull_oe: assert property (p_pull_oe) else $error("pull-up on driven pin");
    c_bdm: cover property ($fell(rst) && active_background);
    c_err: cover property (pslverr);
    c_tick: cover property (debug_bit_tick && armed_reg);
endmodule

bind pfm_pin_mux pfm_pin_mux_checker #(.DBG_BIT_CYCLES(DBG_BIT_CYCLES)) u_chk (
    .clk, .rst, .ce, .apb_req, .pslverr, .por_reset, .force_reset, .active_background,
    .dbg_in, .debug_bit_tick, .adc_en, .acmp_en, .analog_connect, .pad_in, .pad_out,
    .pad_oe, .pad_pullup, .pad_drive_high, .pad_slew);

// ==== verif/pfm_pad_model.sv ====
module pfm_pad_model (
    // clock
    input  wire logic               clk,
    // pad controls and pins pulled low from outside
    input  wire pfm_pkg::pfm_pins_t pad_out,
    input  wire pfm_pkg::pfm_pins_t pad_oe,
    input  wire pfm_pkg::pfm_pins_t pad_pullup,
    input  wire pfm_pkg::pfm_pins_t host_low,
    // resolved levels
    output pfm_pkg::pfm_pins_t      pad_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import pfm_pkg::*;
    // floating pins toggle
    logic flip_reg = 1'b0;
    always_ff @(posedge clk) flip_reg <= ~flip_reg;
    assign pad_in = ~host_low & ((pad_oe & pad_out)
        | (~pad_oe & (pad_pullup | {PFM_NPINS{flip_reg}})));
endmodule

// ==== verif/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pfm_pkg::*;
    logic         clk = 1'b0, rst = 1'b1, ce = 1'b1, por = 1'b1, frc = 1'b0, rdl = 1'b0;
    pfm_apb_req_t req = '0;
    pfm_fn_t      dbg = '0, scl = '0, sda = '0, ch0 = '0, ch1 = '0;
    pfm_vec_t     alt = '0;
    pfm_pins_t    adc = '0, acmp = '0, hl = '0, pin, pout, poe, ppu, pdh, psl, anc, pm, po;
    logic [31:0]  prdata, rd;
    logic         pready, pslverr, err, ext_rq, bgm, dbg_i, tick, scl_i, sda_i, c0_i, c1_i;
    logic [3:0]   mt [5] = '{4'b1011, 4'b0011, 4'b0100, 4'b0111, 4'b1000};
    int           failures = 0, compares = 0, n;

    initial forever #2.5 clk = ~clk;

    pfm_pin_mux u_pfm_pin_mux (
        .clk, .rst, .ce, .apb_req(req), .prdata, .pready,
        .pslverr, .por_reset(por), .force_reset(frc), .reset_drive_low(rdl),
        .ext_reset_req(ext_rq), .active_background(bgm), .dbg_drive(dbg), .dbg_in(dbg_i),
        .debug_bit_tick(tick), .i2c_scl(scl), .i2c_sda(sda), .tmr1_ch0(ch0), .tmr1_ch1(ch1),
        .i2c_scl_in(scl_i), .i2c_sda_in(sda_i), .tmr1_ch0_in(c0_i), .tmr1_ch1_in(c1_i),
        .alt_fn(alt), .adc_en(adc), .acmp_en(acmp), .analog_connect(anc), .pad_in(pin),
        .pad_out(pout), .pad_oe(poe), .pad_pullup(ppu), .pad_drive_high(pdh), .pad_slew(psl));
    pfm_pad_model u_pfm_pad_model (
        .clk, .pad_out(pout), .pad_oe(poe), .pad_pullup(ppu), .host_low(hl), .pad_in(pin));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic to_fail;
        failures++;
        report_and_stop();
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) to_fail();
        rd = prdata;
        err = pslverr;
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(nm, e, rd);
    endtask
    task automatic do_reset(input logic p, input logic f, input logic l);
        @(posedge clk);
        {rst, por, frc, hl[4]} <= {1'b1, p, f, l};
        repeat (16) @(posedge clk);
        {rst, por, frc, hl[4]} <= 4'h0;
        @(posedge clk);
    endtask
    task automatic count_tick(output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (tick !== 1'b1 && k < 40);
        if (k >= 40) to_fail();
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        foreach (mt[i]) begin
            do_reset(mt[i][3], mt[i][2], mt[i][1]);
            cmp("mode", 32'(mt[i][0]), 32'(bgm));
        end
        cmp("reset pads", 32'h10, 32'(ppu | poe));
        cmp("dbg_in", 32'h1, 32'(dbg_i));
        rchk("status", PFM_OFS_STATUS, 32'h2);
        rchk("opts2", PFM_OFS_OPTS2, 32'h0);
        count_tick(n);
        count_tick(n);
        cmp("bit time", 32'd16, 32'(n));
        dbg <= 3'b101;
        repeat (3) @(posedge clk);
        cmp("debug pin", 32'h2, 32'({poe[4], pout[4] | dbg_i}));
        dbg <= '0;
        wr(PFM_OFS_OPTS1, 32'h0);
        rchk("status", PFM_OFS_STATUS, 32'h0);
        wr(PFM_OFS_PULL, 32'h3ffff);
        wr(PFM_OFS_DIR, 32'h000ff);
        wr(PFM_OFS_DATA, 32'h0000a);
        wr(PFM_OFS_DRIVE, 32'h3f0f0);
        wr(PFM_OFS_SLEW, 32'h0ff0f);
        repeat (3) @(posedge clk);
        cmp("pull", 32'h3ff00, 32'(ppu));
        cmp("oe", 32'h000ff, 32'(poe));
        cmp("drive", 32'h000f0, 32'(pdh & poe));
        cmp("slew", 32'h0000f, 32'(psl & poe));
        rchk("data", PFM_OFS_DATA, 32'h3ff0a);
        scl <= 3'b111;
        sda <= 3'b101;
        ch0 <= 3'b111;
        ch1 <= 3'b101;
        alt <= '{18'h00040, 18'h00040, 18'h00040};
        for (int s = 3; s >= 0; s--) begin
            wr(PFM_OFS_OPTS2, 32'(s));
            repeat (3) @(posedge clk);
            pm = 18'h40 | (s[0] ? 18'h03000 : 18'h0000c) | (s[1] ? 18'h0c000 : 18'h00801);
            po = 18'h40 | (s[0] ? 18'h02000 : 18'h00008) | (s[1] ? 18'h04000 : 18'h00001);
            cmp("periph oe", 32'(pm), 32'(poe & pm));
            cmp("periph out", 32'(po), 32'(pout & pm));
            cmp("periph in", 32'ha, 32'({scl_i, sda_i, c0_i, c1_i}));
        end
        rchk("data owned", PFM_OFS_DATA, 32'h3f70a);
        alt <= '0;
        wr(PFM_OFS_OPTS2, 32'h2);
        wr(PFM_OFS_DATA, 32'h0400a);
        wr(PFM_OFS_DRIVE, 32'h04000);
        wr(PFM_OFS_SLEW, 32'h04000);
        wr(PFM_OFS_GANG, 32'h3ffff);
        rchk("gang", PFM_OFS_GANG, 32'(PFM_GANG_MASK));
        repeat (3) @(posedge clk);
        cmp("gang", 32'(PFM_GANG_MASK), 32'(poe & pout & pdh & psl & PFM_GANG_MASK));
        adc <= 18'h08001;
        acmp <= 18'h00001;
        repeat (3) @(posedge clk);
        cmp("analog", 32'h08001, 32'(anc));
        cmp("analog oe", 32'h0, 32'(poe & 18'h08001));
        adc <= '0;
        acmp <= '0;
        wr(PFM_OFS_OPTS1, 32'h2);
        wr(PFM_OFS_OPTS1, 32'h0);
        rchk("status", PFM_OFS_STATUS, 32'h4);
        rdl <= 1'b1;
        repeat (3) @(posedge clk);
        cmp("reset pin", 32'h5, {29'h0, poe[5], pout[5], ext_rq});
        rdl <= 1'b0;
        wr(8'h24, 32'hffffffff);
        cmp("slverr", 32'h1, 32'(err));
        rchk("unmapped", 8'h24, 32'h0);
        do_reset(1'b0, 1'b0, 1'b0);
        rchk("status", PFM_OFS_STATUS, 32'h6);
        do_reset(1'b1, 1'b0, 1'b0);
        fork
            rchk("stalled", PFM_OFS_STATUS, 32'h2);
            begin
                repeat (2) @(posedge clk);
                ce <= 1'b0;
                repeat (5) @(posedge clk);
                ce <= 1'b1;
            end
        join
        report_and_stop();
    end
endmodule
